/* core/sync_output_pkg.sv */
// shared constants, register map and carrier types of the sync output generator
// assumes one 200 MHz clock and a byte-wide internal register port
package sync_output_pkg;

	// register offsets
	localparam logic [7:0] ADDR_ACTIVITY   = 8'h01;
	localparam logic [7:0] ADDR_POLARITY   = 8'h02;
	localparam logic [7:0] ADDR_INPUT_CFG  = 8'h05;
	localparam logic [7:0] ADDR_OUTPUT_CFG = 8'h18;
	localparam logic [7:0] ADDR_LINE_WIDTH = 8'h19;
	localparam logic [7:0] ADDR_POWER      = 8'h1b;
	localparam logic [7:0] ADDR_PLL_TUNE   = 8'h1c;
	localparam logic [7:0] ADDR_DC_RESTORE = 8'h23;

	// reset values
	localparam logic [7:0] RST_INPUT_CFG  = 8'h00;
	localparam logic [7:0] RST_OUTPUT_CFG = 8'h00;
	localparam logic [7:0] RST_LINE_WIDTH = 8'h08;
	localparam logic [7:0] RST_POWER      = 8'h00;
	localparam logic [7:0] RST_PLL_TUNE   = 8'h00;
	localparam logic [7:0] RST_DC_RESTORE = 8'h00;

	localparam logic [7:0] POWER_STANDBY  = 8'h0f;

	// input configuration fields
	localparam int IN_CHAN_BIT      = 0;
	localparam int IN_SYNC_HIGH_BIT = 1;
	localparam int IN_YUV_BIT       = 2;
	localparam int IN_SRC_LO        = 3;
	localparam int IN_SRC_HI        = 4;

	// output configuration fields
	localparam int OUT_WIDE_BIT      = 0;
	localparam int OUT_FRAME_POL_BIT = 6;
	localparam int OUT_LINE_POL_BIT  = 7;

	// activity status fields
	localparam int ACT_LINE_BIT     = 0;
	localparam int ACT_FRAME_BIT    = 1;
	localparam int ACT_GREEN_BIT    = 2;
	localparam int ACT_OVERFLOW_BIT = 7;

	// pixel index of both frame pulse edges
	localparam logic [11:0] PIX_FRAME_EDGE = 12'h007;

	typedef enum logic [1:0] {
		SRC_SEPARATE  = 2'b00,
		SRC_COMPOSITE = 2'b01,
		SRC_GREEN     = 2'b10,
		SRC_GREEN_ALT = 2'b11
	} sync_src_t;

	typedef struct packed {
		logic [23:0] pixel;
		logic        line_start_pulse;
		logic        frame_pulse;
	} pixel_word_t;

	typedef struct packed {
		logic [23:0] adc;
		logic [1:0]  line;
		logic [1:0]  green;
		logic [1:0]  frame;
		logic [1:0]  sliced;
		logic        pclk;
		logic        invert;
	} pin_bundle_t;

	typedef struct packed {
		logic       we;
		logic       re;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

endpackage

/* core/two_entry_buffer.sv */
// two-entry buffer with valid/ready on both sides
// assumes producer and consumer share clk
`timescale 1ns/1ps
module two_entry_buffer #(
	parameter int WIDTH = 26
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready,
	output logic                  out_valid
);
	logic [WIDTH-1:0] head_reg;
	logic [WIDTH-1:0] tail_reg;
	logic [1:0]       count_reg;
	logic             push;
	logic             pop;

	assign in_ready  = (count_reg != 2'h2);
	assign out_valid = (count_reg != 2'h0);
	assign out_data  = head_reg;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_reg <= 2'h0;
		end else if (push && !pop) begin
			count_reg <= count_reg + 2'h1;
		end else if (pop && !push) begin
			count_reg <= count_reg - 2'h1;
		end
	end

	// head always holds the oldest word, so the output needs no mux
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			head_reg <= '0;
			tail_reg <= '0;
		end else begin
			if (pop) begin
				head_reg <= (push && count_reg == 2'h1) ? in_data : tail_reg;
			end else if (push && count_reg == 2'h0) begin
				head_reg <= in_data;
			end
			if (push && (count_reg == 2'h2 || (count_reg == 2'h1 && !pop))) begin
				tail_reg <= in_data;
			end else if (push && pop && count_reg == 2'h2) begin
				tail_reg <= in_data;
			end
		end
	end

endmodule

/* core/sync_output_generator.sv */
// sync pass-through, line start and frame pulse generation, standby and registers
// assumes pins are asynchronous to clk; pixel clock pin is far slower than clk
//
// Function
// - buffered line sync repeats the selected line or green sync unchanged
// - with green sync selected, the whole green waveform goes out
// - buffered frame sync repeats frame input, or sliced pulse when green selected
// - buffered syncs and separator keep running in power-down
// - line start pulse aligned to data clock, trailing edge at pixel 0
// - pulse width from width register, polarity from output config bit 7
// - wider pulse moves leading edge earlier, trailing edge stays
// - in 48-bit or YUV mode width steps by two pixels
// - RGB24 width as written, YUV24 rounded up odd, 48-bit rounded down even
// - frame pulse edges both at pixel 7
// - frame pulse width in lines follows frame sync, polarity bit 6
// - writing 0x0f to power control enters standby
// - registers, activity status and buffered syncs stay alive in standby
// - reset returns every register to its default
// - defaults pick AC-coupled RGB on first channel, 24-bit output
// - phase invert input shifts sampling and data clock by half a period
// - composite sync quirk may lock line pulse to wrong edge briefly
`timescale 1ns/1ps
module sync_output_generator (
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	input  wire logic [1:0]                  line_sync_input,
	input  wire logic [1:0]                  green_embedded_sync_input,
	input  wire logic [1:0]                  frame_sync_input,
	input  wire logic [1:0]                  green_sliced_frame_sync,
	input  wire logic                        pixel_clock_in,
	input  wire logic                        sample_phase_invert,
	input  wire logic [23:0]                 adc_pixel,
	input  wire logic [11:0]                 line_total_pixels,
	input  wire sync_output_pkg::reg_req_t   reg_req,
	output logic [7:0]                       reg_rdata,
	output logic                             buffered_line_sync_out,
	output logic                             buffered_frame_sync_out,
	output logic                             output_data_clock,
	output sync_output_pkg::pixel_word_t     out_word,
	output logic                             out_valid,
	input  wire logic                        out_ready,
	output logic                             standby
);
	sync_output_pkg::pin_bundle_t  pins_s1;
	sync_output_pkg::pin_bundle_t  pins_s2;
	sync_output_pkg::pixel_word_t  cap_word;
	sync_output_pkg::sync_src_t    src;
	logic [7:0]  in_cfg_reg;
	logic [7:0]  out_cfg_reg;
	logic [7:0]  line_width_reg;
	logic [7:0]  power_reg;
	logic [7:0]  pll_tune_reg;
	logic [7:0]  dc_restore_reg;
	logic [7:0]  activity_reg;
	logic [7:0]  activity_set;
	logic [11:0] pix_cnt;
	logic [11:0] pix_cnt_next;
	logic [7:0]  eff_w;
	logic        pclk_d;
	logic        pix_edge;
	logic        pix_fall;
	logic        chan;
	logic        sog_sel;
	logic        line_sel;
	logic        frame_sel;
	logic        green_pick;
	logic        frame_pick;
	logic        line_act;
	logic        line_act_d;
	logic        frame_prev;
	logic        green_prev;
	logic        line_pend;
	logic        hs_active_reg;
	logic        hs_active_next;
	logic        vs_active_reg;
	logic        vs_active_next;
	logic        wide;
	logic        phase_reg;
	logic        cap_valid;
	logic        buf_in_ready;

	// two-stage synchroniser for every pin
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pins_s1 <= '0;
			pins_s2 <= '0;
		end else begin
			pins_s1 <= {adc_pixel, line_sync_input, green_embedded_sync_input,
				frame_sync_input, green_sliced_frame_sync, pixel_clock_in,
				sample_phase_invert};
			pins_s2 <= pins_s1;
		end
	end

	assign standby    = (power_reg == sync_output_pkg::POWER_STANDBY);
	assign chan       = in_cfg_reg[sync_output_pkg::IN_CHAN_BIT];
	assign src        = sync_output_pkg::sync_src_t'(
		in_cfg_reg[sync_output_pkg::IN_SRC_HI:sync_output_pkg::IN_SRC_LO]);
	assign sog_sel    = src[1];
	assign green_pick = pins_s2.green[chan];
	assign frame_pick = sog_sel ? pins_s2.sliced[chan] : pins_s2.frame[chan];
	assign line_sel   = sog_sel ? green_pick : pins_s2.line[chan];
	assign frame_sel  = frame_pick;

	// sync outputs are never gated by standby: mode detection runs powered down
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			buffered_line_sync_out  <= 1'b0;
			buffered_frame_sync_out <= 1'b0;
		end else begin
			buffered_line_sync_out  <= line_sel;
			buffered_frame_sync_out <= frame_sel;
		end
	end

	// pixel clock edges; invert picks the opposite edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pclk_d <= 1'b0;
		end else begin
			pclk_d <= pins_s2.pclk;
		end
	end
	assign pix_edge = (pins_s2.pclk != pclk_d) && (pins_s2.pclk != pins_s2.invert);
	assign pix_fall = (pins_s2.pclk != pclk_d) && (pins_s2.pclk == pins_s2.invert);

	// the counter locks to the leading sync edge; an unserrated composite
	// sync of one polarity can make it pick the wrong edge for a while
	assign line_act = line_sel ^ ~in_cfg_reg[sync_output_pkg::IN_SYNC_HIGH_BIT];
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			line_act_d <= 1'b0;
			line_pend  <= 1'b0;
		end else begin
			line_act_d <= line_act;
			if (line_act && !line_act_d) begin
				line_pend <= 1'b1;
			end else if (pix_edge) begin
				line_pend <= 1'b0;
			end
		end
	end

	assign wide = out_cfg_reg[sync_output_pkg::OUT_WIDE_BIT];
	always_comb begin
		if (wide) begin
			eff_w = {line_width_reg[7:1], 1'b0};
		end else if (in_cfg_reg[sync_output_pkg::IN_YUV_BIT]) begin
			eff_w = line_width_reg | 8'h01;
		end else begin
			eff_w = line_width_reg;
		end
	end

	always_comb begin
		if (line_pend || pix_cnt + 12'h001 >= line_total_pixels) begin
			pix_cnt_next = 12'h000;
		end else begin
			pix_cnt_next = pix_cnt + 12'h001;
		end
	end
	// active for the last eff_w pixels before pixel 0
	assign hs_active_next = ({1'b0, pix_cnt_next} + {5'h00, eff_w}) >=
		{1'b0, line_total_pixels};
	assign vs_active_next = (pix_cnt_next == sync_output_pkg::PIX_FRAME_EDGE) ?
		(frame_sel ^ ~in_cfg_reg[sync_output_pkg::IN_SYNC_HIGH_BIT]) :
		vs_active_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pix_cnt       <= 12'h000;
			hs_active_reg <= 1'b0;
			vs_active_reg <= 1'b0;
		end else if (pix_edge && !standby) begin
			pix_cnt       <= pix_cnt_next;
			hs_active_reg <= hs_active_next;
			vs_active_reg <= vs_active_next;
		end
	end

	// data clock rises on the active pixel edge; 48-bit mode halves it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			output_data_clock <= 1'b0;
			phase_reg         <= 1'b0;
		end else if (standby) begin
			output_data_clock <= 1'b0;
			phase_reg         <= 1'b0;
		end else if (pix_edge) begin
			phase_reg <= wide ? ~phase_reg : 1'b0;
			if (!wide || !phase_reg) begin
				output_data_clock <= 1'b1;
			end else begin
				output_data_clock <= 1'b0;
			end
		end else if (pix_fall && !wide) begin
			output_data_clock <= 1'b0;
		end
	end

	// capture stage; a word still held when the next pixel arrives is overwritten
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cap_valid <= 1'b0;
			cap_word  <= '0;
		end else if (pix_edge && !standby) begin
			cap_valid                 <= 1'b1;
			cap_word.pixel            <= pins_s2.adc;
			cap_word.line_start_pulse <= hs_active_next ^
				out_cfg_reg[sync_output_pkg::OUT_LINE_POL_BIT];
			cap_word.frame_pulse      <= vs_active_next ^
				out_cfg_reg[sync_output_pkg::OUT_FRAME_POL_BIT];
		end else if (buf_in_ready) begin
			cap_valid <= 1'b0;
		end
	end

	two_entry_buffer #(
		.WIDTH ($bits(sync_output_pkg::pixel_word_t))
	) u_buffer (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_data   (cap_word),
		.in_valid  (cap_valid),
		.in_ready  (buf_in_ready),
		.out_data  (out_word),
		.out_ready (out_ready),
		.out_valid (out_valid)
	);

	// activity sticky bits, cleared by reading; a new event wins over the clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			frame_prev <= 1'b0;
			green_prev <= 1'b0;
		end else begin
			frame_prev <= frame_sel;
			green_prev <= green_pick;
		end
	end
	always_comb begin
		activity_set = 8'h00;
		activity_set[sync_output_pkg::ACT_LINE_BIT]     = line_act != line_act_d;
		activity_set[sync_output_pkg::ACT_FRAME_BIT]    = frame_sel != frame_prev;
		activity_set[sync_output_pkg::ACT_GREEN_BIT]    = green_pick != green_prev;
		activity_set[sync_output_pkg::ACT_OVERFLOW_BIT] = pix_edge && !standby &&
			cap_valid && !buf_in_ready;
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			activity_reg <= 8'h00;
		end else if (reg_req.re && reg_req.addr == sync_output_pkg::ADDR_ACTIVITY) begin
			activity_reg <= activity_set;
		end else begin
			activity_reg <= activity_reg | activity_set;
		end
	end

	// writable registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			in_cfg_reg     <= sync_output_pkg::RST_INPUT_CFG;
			out_cfg_reg    <= sync_output_pkg::RST_OUTPUT_CFG;
			line_width_reg <= sync_output_pkg::RST_LINE_WIDTH;
			power_reg      <= sync_output_pkg::RST_POWER;
			pll_tune_reg   <= sync_output_pkg::RST_PLL_TUNE;
			dc_restore_reg <= sync_output_pkg::RST_DC_RESTORE;
		end else if (reg_req.we) begin
			case (reg_req.addr)
				sync_output_pkg::ADDR_INPUT_CFG:  in_cfg_reg     <= reg_req.wdata;
				sync_output_pkg::ADDR_OUTPUT_CFG: out_cfg_reg    <= reg_req.wdata;
				sync_output_pkg::ADDR_LINE_WIDTH: line_width_reg <= reg_req.wdata;
				sync_output_pkg::ADDR_POWER:      power_reg      <= reg_req.wdata;
				sync_output_pkg::ADDR_PLL_TUNE:   pll_tune_reg   <= reg_req.wdata;
				sync_output_pkg::ADDR_DC_RESTORE: dc_restore_reg <= reg_req.wdata;
				default: ;
			endcase
		end
	end

	// read data registered; unmapped offsets read zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_req.re) begin
			case (reg_req.addr)
				sync_output_pkg::ADDR_ACTIVITY:   reg_rdata <= activity_reg;
				sync_output_pkg::ADDR_POLARITY:   reg_rdata <= {6'h00, frame_sel, line_sel};
				sync_output_pkg::ADDR_INPUT_CFG:  reg_rdata <= in_cfg_reg;
				sync_output_pkg::ADDR_OUTPUT_CFG: reg_rdata <= out_cfg_reg;
				sync_output_pkg::ADDR_LINE_WIDTH: reg_rdata <= line_width_reg;
				sync_output_pkg::ADDR_POWER:      reg_rdata <= power_reg;
				sync_output_pkg::ADDR_PLL_TUNE:   reg_rdata <= pll_tune_reg;
				sync_output_pkg::ADDR_DC_RESTORE: reg_rdata <= dc_restore_reg;
				default:                          reg_rdata <= 8'h00;
			endcase
		end
	end

	// width in force at the previous pixel; a width write mid-line moves an edge once
	logic [7:0]  eff_w_prev;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			eff_w_prev <= sync_output_pkg::RST_LINE_WIDTH;
		end else if (pix_edge && !standby) begin
			eff_w_prev <= eff_w;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_cfg_steady;
		in_cfg_reg == $past(in_cfg_reg);
	endsequence

	a_line_sync_pass: assert property (
		s_cfg_steady and (!sog_sel) |=> buffered_line_sync_out == $past(pins_s2.line[chan])
	) else $error("buffered line sync differs from selected input");

	a_green_sync_pass: assert property (
		s_cfg_steady and sog_sel |=> buffered_line_sync_out == $past(green_pick)
	) else $error("buffered line sync lost green sync waveform");

	a_frame_sync_pass: assert property (
		s_cfg_steady |=> buffered_frame_sync_out == $past(frame_pick)
	) else $error("buffered frame sync differs from selected source");

	a_powerdown_live: assert property (
		standby ##1 (standby && $changed(frame_pick)) |=> $changed(buffered_frame_sync_out)
	) else $error("frame sync output frozen in standby");

	a_line_end_zero: assert property (
		pix_edge && !standby && hs_active_reg && !hs_active_next && eff_w == eff_w_prev |=>
			pix_cnt == 12'h000
	) else $error("line pulse ended away from pixel 0");

	a_line_polarity: assert property (
		pix_edge && !standby |=> cap_word.line_start_pulse ==
			($past(hs_active_next) ^ $past(out_cfg_reg[sync_output_pkg::OUT_LINE_POL_BIT]))
	) else $error("line pulse polarity wrong");

	a_line_lead_edge: assert property (
		pix_edge && !standby && !hs_active_reg && hs_active_next && eff_w == eff_w_prev &&
			{4'h0, eff_w} < line_total_pixels |=>
			({1'b0, pix_cnt} + {5'h00, $past(eff_w)}) == {1'b0, line_total_pixels}
	) else $error("line pulse leading edge misplaced");

	a_wide_step: assert property (
		wide |-> eff_w[0] == 1'b0 && eff_w[7:1] == line_width_reg[7:1]
	) else $error("48-bit width not rounded down to even");

	a_yuv_odd: assert property (
		!wide && in_cfg_reg[sync_output_pkg::IN_YUV_BIT] |-> eff_w == (line_width_reg | 8'h01)
	) else $error("yuv width not rounded up to odd");

	a_frame_at_px7: assert property (
		$changed(vs_active_reg) |-> pix_cnt == sync_output_pkg::PIX_FRAME_EDGE
	) else $error("frame pulse edge away from pixel 7");

	a_standby_enter: assert property (
		reg_req.we && reg_req.addr == sync_output_pkg::ADDR_POWER &&
			reg_req.wdata == sync_output_pkg::POWER_STANDBY |=> standby ##1 !output_data_clock
	) else $error("standby not entered on power write");

	a_reset_defaults: assert property (
		$rose(rst_n) |-> in_cfg_reg == sync_output_pkg::RST_INPUT_CFG &&
			out_cfg_reg == sync_output_pkg::RST_OUTPUT_CFG && !standby
	) else $error("registers not at defaults after reset");

	a_phase_invert: assert property (
		pix_edge && !standby && !wide |=> output_data_clock && $past(pins_s2.pclk) != $past(pins_s2.invert)
	) else $error("data clock not on selected pixel edge");

endmodule

/* verification/scaler_model.sv */
// downstream scaler model: takes one word per valid/ready handshake
// assumes the generator's clk; stall is commanded by the bench
`timescale 1ns/1ps
module scaler_model (
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	input  wire sync_output_pkg::pixel_word_t word,
	input  wire logic                         valid,
	input  wire logic                         stall,
	output logic                              ready,
	output logic                              taken,
	output sync_output_pkg::pixel_word_t      got
);
	// ready is registered, so a stall lands one cycle late like a real pipeline
	always_ff @(posedge clk) begin
		ready <= rst_n && !stall;
		taken <= valid && ready;
		if (valid && ready) begin
			got <= word;
		end
	end
endmodule

/* verification/sync_output_generator_tb.sv */
// self-checking bench for the sync output generator and a scaler model
// assumes registered read data and 3-cycle sync copies; 16 pixels, 6 lines
`timescale 1ns/1ps
module sync_output_generator_tb;
	localparam logic [7:0] CI [7] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] CO [7] = '{8'h00, 8'h80, 8'h00, 8'h40, 8'h01, 8'h41, 8'h00};
	localparam logic [7:0] CW [7] = '{8'h03, 8'h04, 8'h04, 8'h03, 8'h03, 8'h04, 8'h05};
	localparam logic [7:0] CE [7] = '{8'h03, 8'h04, 8'h05, 8'h03, 8'h02, 8'h04, 8'h00};
	logic                         clk = 1'b0, rst_n = 1'b0, pclk = 1'b0, inv = 1'b0;
	logic [1:0]                   line_s = 2'h3, green_s = 2'h3, frame_s = 2'h3, slice_s = 2'h3;
	logic [23:0]                  adc = 24'h0, last_pix;
	sync_output_pkg::reg_req_t    req = '0;
	sync_output_pkg::pixel_word_t word, got;
	logic [7:0]                   rdata, re_e, re_m, rq [$], mq [$];
	logic                         bl, bf, odc, ov, ordy, stby, taken, stall = 1'b0;
	logic                         odc_q, fp_q, rd_flag = 1'b0, lpol = 1'b0;
	bit                           rand_sync, chk_pix, chk_odc, frm_on, fseen, have_pix, p0_ok;
	bit                           rnd_stall, hold, composite_sync_fix;
	logic [3:0]                   ph = 4'h0, pix = 4'h0, p0;
	int                           seed = 32'h4eed, err_total, total_checks, cyc, ln, run, idx;
	int                           lines, nt;
	int                           wq [$];

	always #2.5 clk = ~clk;

	sync_output_generator sync_output_generator_i (.clk(clk), .rst_n(rst_n),
		.line_sync_input(line_s), .green_embedded_sync_input(green_s),
		.frame_sync_input(frame_s), .green_sliced_frame_sync(slice_s),
		.pixel_clock_in(pclk), .sample_phase_invert(inv), .adc_pixel(adc),
		.line_total_pixels(12'h010), .reg_req(req), .reg_rdata(rdata),
		.buffered_line_sync_out(bl), .buffered_frame_sync_out(bf),
		.output_data_clock(odc), .out_word(word), .out_valid(ov), .out_ready(ordy),
		.standby(stby));
	scaler_model scaler_model_i (.clk(clk), .rst_n(rst_n), .word(word), .valid(ov),
		.stall(stall), .ready(ordy), .taken(taken), .got(got));

	// pixel clock of 80 ns, counting pixels and sixteen-pixel lines
	always @(negedge clk) begin
		ph <= ph + 4'h1;
		stall <= hold || (rnd_stall && (($random(seed) & 3) == 0));
		if (ph == 4'h8) pclk <= 1'b1;
		if (ph == 4'h0) begin
			pclk <= 1'b0;
			adc <= adc + 24'h1;
			pix <= pix + 4'h1;
			if (pix == 4'hf) ln <= (ln == 5) ? 0 : ln + 1;
			if (!rand_sync) begin
				// host gpio into the external xor stays low: no troublesome composite mode here
				line_s <= ((pix >= 4'he) ? 2'h0 : 2'h3) ^ {2{composite_sync_fix}};
				frame_s <= (ln == 0) ? 2'h0 : 2'h3;
			end
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req <= {1'b1, 1'b0, a, d};
		@(negedge clk);
		req <= '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		rq.push_back(e);
		mq.push_back(m);
		@(negedge clk);
		req <= {1'b0, 1'b1, a, 8'h00};
		@(negedge clk);
		req <= '0;
	endtask

	task automatic sync_chk(input int s);
		chk("line sync out", 32'(s[2] ? green_s[s[0]] : line_s[s[0]]), 32'(bl));
		if (s[2:1] != 2'b01) chk("frame sync out", 32'(s[2] ? slice_s[s[0]] : frame_s[s[0]]), 32'(bf));
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// result watcher: read data and words taken by the scaler
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			wrap_up();
		end
		if (rd_flag && rq.size() > 0) begin
			re_e = rq.pop_front();
			re_m = mq.pop_front();
			chk("reg_rdata", 32'(re_e & re_m), 32'(rdata & re_m));
		end
		rd_flag = req.re;
		if (odc && !odc_q && chk_odc) chk("data clock phase", 32'(!inv), 32'(pclk));
		odc_q = odc;
		if (taken) begin
			nt++;
			if (chk_pix && have_pix) chk("pixel", 32'(last_pix + 24'h1), 32'(got.pixel));
			last_pix = got.pixel;
			have_pix = chk_pix;
			if (got.line_start_pulse ^ lpol) run++;
			else if (run > 0) begin
				if (wq.size() > 0) begin
					chk("line width", wq.pop_front(), run);
					if (p0_ok) chk("pixel 0 phase", 32'(p0), 32'(got.pixel[3:0]));
					p0 = got.pixel[3:0];
					p0_ok = 1;
				end
				run = 0;
				idx = 0;
				lines++;
			end else idx++;
			if (frm_on && got.frame_pulse !== fp_q) begin
				chk("frame edge pixel", 7, idx);
				if (fseen) chk("frame lines", 1, 32'(lines == 1 || lines == 5));
				fseen = 1;
				lines = 0;
			end
			fp_q = got.frame_pulse;
		end
	end

	initial begin
		repeat (2) @(negedge clk);
		rst_n <= 1'b1;
		rd(sync_output_pkg::ADDR_INPUT_CFG, sync_output_pkg::RST_INPUT_CFG, 8'hff);
		rd(sync_output_pkg::ADDR_OUTPUT_CFG, sync_output_pkg::RST_OUTPUT_CFG, 8'hff);
		rd(sync_output_pkg::ADDR_LINE_WIDTH, sync_output_pkg::RST_LINE_WIDTH, 8'hff);
		rd(sync_output_pkg::ADDR_POWER, sync_output_pkg::RST_POWER, 8'hff);
		rd(8'h7e, 8'h00, 8'hff);
		wr(sync_output_pkg::ADDR_PLL_TUNE, 8'h49);
		wr(sync_output_pkg::ADDR_DC_RESTORE, 8'h78);
		rd(sync_output_pkg::ADDR_PLL_TUNE, 8'h49, 8'hff);
		rd(sync_output_pkg::ADDR_DC_RESTORE, 8'h78, 8'hff);
		$display("test registers done");
		rand_sync = 1;
		for (int p = 0; p < 2; p++) begin
			if (p == 1) wr(sync_output_pkg::ADDR_POWER, sync_output_pkg::POWER_STANDBY);
			for (int s = 0; s < 8; s++) begin
				wr(sync_output_pkg::ADDR_INPUT_CFG, {3'h0, 2'(s >> 1), 2'h0, 1'(s)});
				repeat (6) begin
					@(negedge clk);
					{line_s, green_s, frame_s, slice_s} <= 8'($random(seed));
					repeat (4) @(negedge clk);
					sync_chk(s);
				end
			end
			chk("standby", 32'(p), 32'(stby));
			$display("test sync copies done");
		end
		rand_sync = 0;
		rd(sync_output_pkg::ADDR_POWER, 8'h0f, 8'hff);
		repeat (40) @(negedge clk);
		nt = 0;
		repeat (256) @(negedge clk);
		chk("words in standby", 0, nt);
		wr(sync_output_pkg::ADDR_POWER, 8'h00);
		rnd_stall = 1;
		for (int i = 0; i < 7; i++) begin
			frm_on = 0;
			chk_pix = 0;
			chk_odc = 0;
			@(negedge clk);
			inv <= (i == 6);
			wr(sync_output_pkg::ADDR_INPUT_CFG, CI[i]);
			wr(sync_output_pkg::ADDR_OUTPUT_CFG, CO[i]);
			wr(sync_output_pkg::ADDR_LINE_WIDTH, CW[i]);
			lpol = CO[i][7];
			repeat (768) @(negedge clk);
			frm_on = 1;
			chk_pix = 1;
			chk_odc = 1;
			fseen = 0;
			if (i < 6) wq.push_back(CE[i]);
			repeat (1536) @(negedge clk);
			chk("widths taken", 0, wq.size());
			$display("test stream config %0d done", i);
		end
		chk_pix = 0;
		rnd_stall = 0;
		rd(sync_output_pkg::ADDR_ACTIVITY, 8'h00, 8'h00);
		hold = 1;
		repeat (96) @(negedge clk);
		hold = 0;
		repeat (32) @(negedge clk);
		// full buffer refuses: sticky flag, then cleared by the read
		rd(sync_output_pkg::ADDR_ACTIVITY, 8'h80, 8'h80);
		rd(sync_output_pkg::ADDR_ACTIVITY, 8'h00, 8'h80);
		$display("test overflow done");
		rst_n <= 1'b0;
		repeat (2) @(negedge clk);
		rst_n <= 1'b1;
		rd(sync_output_pkg::ADDR_PLL_TUNE, sync_output_pkg::RST_PLL_TUNE, 8'hff);
		rd(sync_output_pkg::ADDR_POWER, sync_output_pkg::RST_POWER, 8'hff);
		repeat (2) @(negedge clk);
		$display("test second reset done");
		wrap_up();
	end
endmodule
